// File: pulse_on_timer.v
`timescale 1ns/10ps
`include "pulse_wetting_map.vh"

module pulse_on_timer #(
    parameter UNIT_CYCLES = 6400,
    parameter CNT_W       = 16
) (
    input  wire                   clk,      // device clock
    input  wire                   rst_n,    // synchronised reset, low
    input  wire                   start,    // launch one pulse
    input  wire [`PTL_TIME_W-1:0] code,     // on-time code at launch
    output reg                    active,   // pulse in progress
    output reg                    done      // one-cycle strobe as active falls
);

    localparam ST_IDLE = 1'b0;
    localparam ST_ON   = 1'b1;
    localparam [CNT_W-1:0] UNIT_W = UNIT_CYCLES;
    localparam [CNT_W-1:0] ONE_W  = 1;

    reg              state_r;
    reg  [CNT_W-1:0] cnt_r;
    wire [CNT_W-1:0] steps;
    wire [2*CNT_W-1:0] prod;
    wire [CNT_W-1:0] total;

    // on-time is (code + 1) units
    assign steps = {{(CNT_W-`PTL_TIME_W){1'b0}}, code} + ONE_W;
    assign prod  = steps * UNIT_W;
    assign total = prod[CNT_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= {CNT_W{1'b0}};
            active  <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_ON;
                        cnt_r   <= total - ONE_W;
                        active  <= 1'b1;
                    end
                end
                ST_ON: begin
                    if (cnt_r == {CNT_W{1'b0}}) begin
                        state_r <= ST_IDLE;
                        active  <= 1'b0;
                        done    <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - ONE_W;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    active  <= 1'b0;
                end
            endcase
        end
    end

endmodule

// File: pulse_wetting_map.vh
`ifndef PULSE_WETTING_MAP_VH
`define PULSE_WETTING_MAP_VH

// register offsets
`define PTL_OFFSET        6'h1F
`define PIE_OFFSET        6'h20
`define CMT_OFFSET        6'h21

// register geometry
`define REG_ADDR_W        6
`define REG_DATA_W        24
`define NUM_INPUTS        24

// pulse_time_and_level fields
`define PTL_TIME_MSB      6
`define PTL_TIME_LSB      4
`define PTL_TIME_W        3
`define PTL_LVL_MSB       3
`define PTL_LVL_LSB       0
`define PTL_LVL_W         4
`define PTL_USED_W        7

// comparator_thresholds fields
`define CMT_USED_W        12
`define CMT_FIELD_W       2
`define CMT_GROUPS        6

// reset values
`define PTL_RESET         7'h00
`define PIE_RESET         24'h000000
`define CMT_RESET         12'h000
`define DATA_ZERO         24'h000000

// input grouping
`define LVL_GRP_SIZE      6
`define THR_GRP_SIZE      4

// pulse current level codes
`define LVL_10MA          1'b0
`define LVL_15MA          1'b1

// comparator threshold codes
`define THR_2V0           2'h0
`define THR_2V7           2'h1
`define THR_3V0           2'h2
`define THR_4V0           2'h3

// timing
`define CLK_PERIOD_NS     10
`define PULSE_UNIT_NS     64000
`define PULSE_CNT_W       16

`endif

// File: pulse_wetting_threshold_cfg.v
`timescale 1ns/10ps
`include "pulse_wetting_map.vh"

// Overview of operation
// - Time bits 6-4 pick a pulse on-time of (code+1) x 64 us.
// - Level bit 3 picks 10 mA (0) or 15 mA (1) for inputs 18-23.
// - Level bit 2 picks the pulse current level for inputs 12-17.
// - Level bit 1 picks the pulse current level for inputs 6-11.
// - Level bit 0 picks the pulse current level for inputs 0-5.
// - Bit n of pulse_input_enables turns pulsed current on for input n.
// - pulse_input_enables sits at 20h, is read/write and resets to zero.
// - A 2-bit threshold code means 2 V, 2.7 V, 3 V or 4 V for its group.
// - Threshold bits 11-10 set the comparator level for inputs 20-23.
// - Threshold bits 9-8 set the comparator level for inputs 16-19.
// - Threshold bits 7-6 set the comparator level for inputs 12-15.
// - Threshold bits 5-4 set the comparator level for inputs 8-11.
// - Threshold bits 3-2 set the comparator level for inputs 4-7.
// - Threshold bits 1-0 set the comparator level for inputs 0-3.
// - comparator_thresholds sits at 21h and resets to zero, lowest threshold.
module pulse_wetting_threshold_cfg #(
    parameter UNIT_CYCLES = `PULSE_UNIT_NS / `CLK_PERIOD_NS,
    parameter CNT_W       = `PULSE_CNT_W
) (
    input  wire                     CLK,          // 100 MHz device clock
    input  wire                     RST_N,        // async reset, low
    input  wire [`REG_ADDR_W-1:0]   REG_ADDR,     // register offset
    input  wire [`REG_DATA_W-1:0]   REG_WDATA,    // write data
    input  wire                     REG_WR,       // write strobe
    input  wire                     REG_RD,       // read strobe
    output reg  [`REG_DATA_W-1:0]   REG_RDATA,    // read data
    output reg                      REG_RVALID,   // read data valid
    output reg                      REG_ERR,      // unmapped access
    input  wire                     PULSE_START,  // pulse request
    output reg                      PULSE_BUSY,   // pulse in progress
    output reg                      PULSE_DONE,   // pulse finished
    output reg  [`NUM_INPUTS-1:0]   PULSE_EN,     // per-input enable
    output reg  [`NUM_INPUTS-1:0]   PULSE_LEVEL,  // per-input 15 mA select
    output reg  [`NUM_INPUTS-1:0]   PULSE_ON_LO,  // 10 mA source on
    output reg  [`NUM_INPUTS-1:0]   PULSE_ON_HI,  // 15 mA source on
    output reg  [2*`NUM_INPUTS-1:0] CMP_LEVEL,    // per-input code
    output reg  [4*`CMT_GROUPS-1:0] THR_ONEHOT    // per-group one-hot
);

    ////////////////////////////////////////////////////////////////////////
    // reset release
    reg rst_meta_r;
    reg rst_sync_r;

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire rst_n;
    assign rst_n = rst_sync_r;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    reg  [`PTL_USED_W-1:0]  ptl_r;
    reg  [`NUM_INPUTS-1:0]  pie_r;
    reg  [`CMT_USED_W-1:0]  cmt_r;
    reg                     hit_ptl;
    reg                     hit_pie;
    reg                     hit_cmt;
    wire                    hit_any;

    always @* begin
        hit_ptl = 1'b0;
        hit_pie = 1'b0;
        hit_cmt = 1'b0;
        if (REG_ADDR == `PTL_OFFSET) begin
            hit_ptl = 1'b1;
        end else if (REG_ADDR == `PIE_OFFSET) begin
            hit_pie = 1'b1;
        end else if (REG_ADDR == `CMT_OFFSET) begin
            hit_cmt = 1'b1;
        end
    end

    assign hit_any = hit_ptl | hit_pie | hit_cmt;

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ptl_r <= `PTL_RESET;
        end else if (REG_WR && hit_ptl) begin
            // only the used low bits are stored
            ptl_r <= REG_WDATA[`PTL_USED_W-1:0];
        end
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pie_r <= `PIE_RESET;
        end else if (REG_WR && hit_pie) begin
            pie_r <= REG_WDATA;
        end
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cmt_r <= `CMT_RESET;
        end else if (REG_WR && hit_cmt) begin
            cmt_r <= REG_WDATA[`CMT_USED_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads
    reg [`REG_DATA_W-1:0] rdata_nxt;

    always @* begin
        rdata_nxt = `DATA_ZERO;
        if (hit_ptl) begin
            rdata_nxt[`PTL_USED_W-1:0] = ptl_r;
        end else if (hit_pie) begin
            rdata_nxt = pie_r;
        end else if (hit_cmt) begin
            rdata_nxt[`CMT_USED_W-1:0] = cmt_r;
        end
    end

    // read data holds until the next read
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= `DATA_ZERO;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_nxt;
        end
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
        end
    end

    // unmapped offset: write dropped, read gives zero
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_ERR <= 1'b0;
        end else begin
            REG_ERR <= (REG_RD | REG_WR) & ~hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse launch and queueing
    wire                   tmr_active;
    wire                   tmr_done;
    reg                    pending_r;
    reg                    pending_nxt;
    wire                   launch;
    wire [`PTL_TIME_W-1:0] time_code;
    wire [`PTL_LVL_W-1:0]  lvl_code;

    assign time_code = ptl_r[`PTL_TIME_MSB:`PTL_TIME_LSB];
    assign lvl_code  = ptl_r[`PTL_LVL_MSB:`PTL_LVL_LSB];
    // a request during a pulse waits for it to end
    assign launch    = (PULSE_START | pending_r) & ~tmr_active;

    always @* begin
        if (launch) begin
            pending_nxt = pending_r & PULSE_START;
        end else begin
            pending_nxt = pending_r | PULSE_START;
        end
    end

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pending_r <= 1'b0;
        end else begin
            pending_r <= pending_nxt;
        end
    end

    pulse_on_timer #(
        .UNIT_CYCLES (UNIT_CYCLES),
        .CNT_W       (CNT_W)
    ) u_timer (
        .clk    (CLK),
        .rst_n  (rst_n),
        .start  (launch),
        .code   (time_code),
        .active (tmr_active),
        .done   (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-pulse snapshot, so a mid-pulse write cannot shorten a pulse
    reg [`NUM_INPUTS-1:0] en_snap_r;
    reg [`NUM_INPUTS-1:0] lvl_snap_r;
    reg [`NUM_INPUTS-1:0] lvl_map;

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            en_snap_r  <= `PIE_RESET;
            lvl_snap_r <= `PIE_RESET;
        end else if (launch) begin
            en_snap_r  <= pie_r;
            lvl_snap_r <= lvl_map;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-input fan-out of level, enable and threshold
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_INPUTS; gi = gi + 1) begin : g_in
            // group bit gi/6: bit 0 inputs 0-5 ... bit 3 inputs 18-23
            always @* begin
                lvl_map[gi] = lvl_code[gi / `LVL_GRP_SIZE];
            end

            always @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    PULSE_EN[gi]    <= 1'b0;
                    PULSE_LEVEL[gi] <= `LVL_10MA;
                    PULSE_ON_LO[gi] <= 1'b0;
                    PULSE_ON_HI[gi] <= 1'b0;
                    CMP_LEVEL[2*gi+1:2*gi] <= `THR_2V0;
                end else begin
                    PULSE_EN[gi]    <= pie_r[gi];
                    PULSE_LEVEL[gi] <= lvl_map[gi];
                    PULSE_ON_LO[gi] <= tmr_active & en_snap_r[gi] &
                                       (lvl_snap_r[gi] == `LVL_10MA);
                    PULSE_ON_HI[gi] <= tmr_active & en_snap_r[gi] &
                                       (lvl_snap_r[gi] == `LVL_15MA);
                    // group gi/4 field: 0 bits 1-0 ... 5 bits 11-10
                    CMP_LEVEL[2*gi+1:2*gi] <=
                        cmt_r[2*(gi/`THR_GRP_SIZE)+1 -: `CMT_FIELD_W];
                end
            end
        end
    endgenerate

    generate
        for (gi = 0; gi < `CMT_GROUPS; gi = gi + 1) begin : g_thr
            wire [`CMT_FIELD_W-1:0] fld;
            assign fld = cmt_r[2*gi+1 -: `CMT_FIELD_W];

            always @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    THR_ONEHOT[4*gi+3:4*gi] <= 4'h1;
                end else begin
                    // lines 0..3 select 2 V, 2.7 V, 3 V, 4 V
                    THR_ONEHOT[4*gi]   <= (fld == `THR_2V0);
                    THR_ONEHOT[4*gi+1] <= (fld == `THR_2V7);
                    THR_ONEHOT[4*gi+2] <= (fld == `THR_3V0);
                    THR_ONEHOT[4*gi+3] <= (fld == `THR_4V0);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pulse status
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PULSE_BUSY <= 1'b0;
        end else begin
            PULSE_BUSY <= tmr_active;
        end
    end

    // done rises in the cycle busy first reads low
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PULSE_DONE <= 1'b0;
        end else begin
            PULSE_DONE <= tmr_done;
        end
    end

endmodule

// File: pwtc_checker.sv
`timescale 1ns/10ps
`include "pulse_wetting_map.vh"

module pwtc_checker #(
    parameter UNIT_CYCLES = 4,
    parameter CNT_W       = 16
) (
    input logic        CLK,         // clock
    input logic        RST_N,       // reset, low
    input logic [5:0]  REG_ADDR,    // offset
    input logic        REG_RD,      // read strobe
    input logic [23:0] REG_RDATA,   // read data
    input logic        REG_RVALID,  // read valid
    input logic        PULSE_BUSY,  // pulse running
    input logic        PULSE_DONE,  // pulse end
    input logic [23:0] PULSE_EN,    // enables
    input logic [23:0] PULSE_LEVEL, // level select
    input logic [23:0] PULSE_ON_LO, // low source on
    input logic [23:0] PULSE_ON_HI, // high source on
    input logic [47:0] CMP_LEVEL,   // per-input code
    input logic [23:0] THR_ONEHOT   // per-group one-hot
);

default clocking @(posedge CLK); endclocking
default disable iff (!RST_N);

logic [CNT_W-1:0] bcnt_r;
logic [23:0]      oh_exp;

// length of the current busy run
always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) bcnt_r <= '0;
    else if (PULSE_BUSY) bcnt_r <= bcnt_r + 1'b1;
    else bcnt_r <= '0;
end

always_comb begin
    for (int g = 0; g < 6; g++) oh_exp[4*g+:4] = 4'h1 << CMP_LEVEL[8*g+:2];
end

////////////////////////////////////////////////////////////////////////////
property p_pie_rd;
    REG_RD && REG_ADDR == `PIE_OFFSET |=>
        REG_RVALID && REG_RDATA == PULSE_EN;
endproperty
a_pie_rd: assert property (p_pie_rd)
    else $error("enable readback differs");
property p_cmt_rd;
    REG_RD && REG_ADDR == `CMT_OFFSET |=> CMP_LEVEL ==
        {{4{REG_RDATA[11:10]}}, {4{REG_RDATA[9:8]}}, {4{REG_RDATA[7:6]}},
         {4{REG_RDATA[5:4]}}, {4{REG_RDATA[3:2]}}, {4{REG_RDATA[1:0]}}};
endproperty
a_cmt_rd: assert property (p_cmt_rd)
    else $error("group threshold mapping wrong");
property p_cmt_rsv;
    REG_RVALID && $past(REG_ADDR) == `CMT_OFFSET |->
        REG_RDATA[23:12] == 12'h000;
endproperty
a_cmt_rsv: assert property (p_cmt_rsv)
    else $error("threshold reserved bits not zero");
property p_ptl_rd;
    REG_RD && REG_ADDR == `PTL_OFFSET |=> REG_RDATA[23:7] == 17'h00000 &&
        PULSE_LEVEL == {{6{REG_RDATA[3]}}, {6{REG_RDATA[2]}},
                        {6{REG_RDATA[1]}}, {6{REG_RDATA[0]}}};
endproperty
a_ptl_rd: assert property (p_ptl_rd)
    else $error("level grouping or reserved bits wrong");
property p_onehot;
    THR_ONEHOT == oh_exp;
endproperty
a_onehot: assert property (p_onehot)
    else $error("threshold one-hot mismatch");
property p_on_idle;
    !PULSE_BUSY |-> (PULSE_ON_LO | PULSE_ON_HI) == 24'h000000;
endproperty
a_on_idle: assert property (p_on_idle)
    else $error("source on while idle");
property p_on_sel;
    $rose(PULSE_BUSY) |-> PULSE_ON_HI == (PULSE_EN & PULSE_LEVEL) &&
        PULSE_ON_LO == (PULSE_EN & ~PULSE_LEVEL);
endproperty
a_on_sel: assert property (p_on_sel)
    else $error("wrong sources switched on");
property p_done;
    $fell(PULSE_BUSY) |-> PULSE_DONE ##1 !PULSE_DONE;
endproperty
a_done: assert property (p_done)
    else $error("done pulse missing");
property p_busy_len;
    $fell(PULSE_BUSY) |-> bcnt_r % UNIT_CYCLES == 0 && bcnt_r != 0 &&
        bcnt_r <= 8 * UNIT_CYCLES;
endproperty
a_busy_len: assert property (p_busy_len)
    else $error("pulse length not a unit multiple");

c_pulse: cover property ($fell(PULSE_BUSY));
c_cmt: cover property (REG_RD && REG_ADDR == `CMT_OFFSET);
c_hi: cover property ($rose(PULSE_BUSY) && PULSE_ON_HI != 24'h000000);

endmodule

bind pulse_wetting_threshold_cfg pwtc_checker #(
    .UNIT_CYCLES(UNIT_CYCLES), .CNT_W(CNT_W)) pwtc_checker_i (
    .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .PULSE_BUSY(PULSE_BUSY), .PULSE_DONE(PULSE_DONE), .PULSE_EN(PULSE_EN),
    .PULSE_LEVEL(PULSE_LEVEL), .PULSE_ON_LO(PULSE_ON_LO),
    .PULSE_ON_HI(PULSE_ON_HI), .CMP_LEVEL(CMP_LEVEL),
    .THR_ONEHOT(THR_ONEHOT));

// File: tb_top.sv
`timescale 1ns/10ps
`include "pulse_wetting_map.vh"

module tb_top;
localparam int U = 4;
logic        CLK = 1'b0;
logic        RST_N = 1'b0;
logic [5:0]  REG_ADDR = 6'h00;
logic [23:0] REG_WDATA = 24'h000000;
logic        REG_WR = 1'b0;
logic        REG_RD = 1'b0;
logic        PULSE_START = 1'b0;
wire  [23:0] REG_RDATA, PULSE_EN, PULSE_LEVEL, PULSE_ON_LO, PULSE_ON_HI;
wire  [23:0] THR_ONEHOT;
wire  [47:0] CMP_LEVEL;
wire         REG_RVALID, REG_ERR, PULSE_BUSY, PULSE_DONE;
int          num_errors = 0;
int          cmp_count = 0;
logic [47:0] e48;

pulse_wetting_threshold_cfg #(.UNIT_CYCLES(U), .CNT_W(16))
    pulse_wetting_threshold_cfg_i (
    .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .REG_ERR(REG_ERR), .PULSE_START(PULSE_START),
    .PULSE_BUSY(PULSE_BUSY), .PULSE_DONE(PULSE_DONE), .PULSE_EN(PULSE_EN),
    .PULSE_LEVEL(PULSE_LEVEL), .PULSE_ON_LO(PULSE_ON_LO),
    .PULSE_ON_HI(PULSE_ON_HI), .CMP_LEVEL(CMP_LEVEL),
    .THR_ONEHOT(THR_ONEHOT));

always #5 CLK = ~CLK;

////////////////////////////////////////////////////////////////////////////
task chk(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
        num_errors++;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
endtask

task summarize;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask

task wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
endtask

task rd(input logic [5:0] a, input logic [23:0] exp);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RVALID, 1);
    chk(REG_RDATA, exp);
endtask

// outputs follow a register one edge after the write is taken
task settle;
    repeat (2) @(posedge CLK);
    #1;
endtask

task pulse(input int code, input logic [23:0] lo, input logic [23:0] hi);
    int n;
    int w;
    @(posedge CLK);
    PULSE_START <= 1'b1;
    @(posedge CLK);
    PULSE_START <= 1'b0;
    n = 0;
    for (w = 0; w < 100 && !(n > 0 && PULSE_BUSY === 1'b0); w++) begin
        @(posedge CLK);
        #1;
        if (PULSE_BUSY === 1'b1) n++;
        if (n == 1 && PULSE_BUSY === 1'b1) begin
            chk(PULSE_ON_LO, lo);
            chk(PULSE_ON_HI, hi);
        end
    end
    chk(PULSE_DONE, 1);
    chk(n, (code + 1) * U);
endtask

initial begin
    #50000;
    num_errors++;
    summarize;
end

initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk(THR_ONEHOT, 24'h111111);
    rd(`PTL_OFFSET, 24'h000000);
    rd(`PIE_OFFSET, 24'h000000);
    rd(`CMT_OFFSET, 24'h000000);
    wr(`PIE_OFFSET, 24'hA5C33C);
    rd(`PIE_OFFSET, 24'hA5C33C);
    wr(`PIE_OFFSET, 24'hFFFFFF);
    settle;
    chk(PULSE_EN, 24'hFFFFFF);
    // unmapped write is dropped
    wr(6'h22, 24'h123456);
    #1;
    chk(REG_ERR, 1);
    rd(`PIE_OFFSET, 24'hFFFFFF);
    for (int k = 0; k < 4; k++) begin
        wr(`CMT_OFFSET, {12'hFFF, {6{k[1:0]}}});
        rd(`CMT_OFFSET, {12'h000, {6{k[1:0]}}});
        settle;
        chk(CMP_LEVEL, {24{k[1:0]}});
        chk(THR_ONEHOT, {6{4'h1 << k}});
    end
    wr(`CMT_OFFSET, 24'h0004E4);
    settle;
    for (int n = 0; n < 24; n++) e48[2*n+:2] = 2'((n / 4) % 4);
    chk(CMP_LEVEL, e48);
    chk(THR_ONEHOT, 24'h218421);
    wr(`PTL_OFFSET, 24'hFFFFFF);
    rd(`PTL_OFFSET, 24'h00007F);
    for (int g = 0; g < 4; g++) begin
        wr(`PTL_OFFSET, 24'h000001 << g);
        settle;
        chk(PULSE_LEVEL, 24'h00003F << (6 * g));
    end
    wr(`PIE_OFFSET, 24'h800001);
    for (int c = 0; c < 8; c++) begin
        wr(`PTL_OFFSET, {17'h00000, c[2:0], c[0] ? 4'hA : 4'h5});
        settle;
        if (c[0]) pulse(c, 24'h000001, 24'h800000);
        else pulse(c, 24'h800000, 24'h000001);
    end
    summarize;
end

endmodule
